// *** rtl/t1l_phy_mgmt_regs.sv ***
// Notes on behaviour
// RL1: While reset is low nothing links and no management access is answered.
// RL2: The clock/LED pin carries a buffered copy of the crystal clock; here a copy resampled on clk_in, held low while reset is low.
// RL3: The host keeps the management clock at or below 1.75 MHz.
// RL4: Addresses above 0x1F are reached only through indirect access.
// RL5: Register 0x3 always reads the fixed model and revision code.
// RL6: Some reset values follow the straps sampled at power-up.
// RL7: Basic control resets to 0x0000; bit 15 digital reset, bit 14 loopback.
// RL8: Register 0x0010 bit 0 shows whether the link is up.
// RL9: Register 0x0015 counts receive errors from zero after reset.
// RL10: Register 0x0016 resets to 0x0100; bit 8 sleep, bits 6-0 loopbacks.
// RL11: Register 0x0017 resets to 0x4001; bits 12:11 shift mode, bit 9 enable.
// RL12: Register 0x0017 bit 7 gives crystal rate, bit 5 interface choice.
// RL13: Register 0x012A flags receive CRC in bit 1, transmit CRC in bit 0.
// RL14: Register 0x012D counts transmitted packets with CRC errors.
// RL15: Register 0x0130 counts received packets with CRC errors.
// RL16: Register 0x0200 resets to 0x1000; bit 15 restarts, bit 12 enables.
// RL17: Register 0x20E resets to 0xA000; bits 15-12 are the advertisements.
// RL18: Register 0x18F6 resets to zero; bit 12 level, bit 10 EEE.
// RL19: Two transmit amplitudes exist, 2.4 V and 1 V peak-to-peak.
// RL20: Level bit one forces 2.4 V, zero forces 1 V.
// RL21: MAC-side loopback sits in basic control, the others in 0x0016.
// RL22: Reset transmit level equals the strap and shows in 0x18F6 bit 12.
// RL23: Direct frames follow clause 22: 5-bit PHY, 5-bit register, 16 data.
`timescale 1ns/100ps
`default_nettype none
module t1l_phy_mgmt_regs
    import t1l_mgmt_pkg::*;
#(
    parameter logic [15:0] MODEL_ID = 16'h5A10 // Arbitrary value.
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic crystal_input_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    input wire logic [4:0] phy_addr_strap_in,
    input wire logic tx_level_strap_in,
    input wire logic xtal50_strap_in,
    input wire logic link_up_in,
    input wire logic rx_error_in,
    input wire logic tx_crc_err_in,
    input wire logic rx_crc_err_in,
    input wire logic [15:0] partner_adv_in,
    output logic refclk_out_led_pin_out,
    output logic digital_reset_out,
    output logic mii_loopback_out,
    output logic [6:0] loop_mode_out,
    output logic sleep_out,
    output logic [15:0] mac_config_out,
    output logic autoneg_en_out,
    output logic autoneg_restart_out,
    output logic [15:0] an_adv_out,
    output logic tx_level_2v4_out,
    output logic eee_en_out
);
    logic [9:0] pin_q1_r;
    logic [9:0] pin_q2_r;
    logic mdc_d_r;
    logic mdc_rise;
    logic mdio_bit;
    logic [1:0] start_cnt_r;
    logic strap_done_r;
    logic init_r;
    logic [4:0] phy_addr_r;
    logic txl_strap_r;
    logic x50_strap_r;
    logic defaults;
    frame_state_t state_r;
    logic [3:0] cnt_r;
    logic [5:0] ones_r;
    logic [11:0] hdr_r;
    logic [12:0] hdr_full;
    logic [15:0] sh_r;
    logic is_rd_r;
    logic hit_r;
    logic mdio_out_r;
    logic mdio_oe_r;
    logic wr_pulse_r;
    logic [15:0] wr_addr_r;
    logic [15:0] wr_data_r;
    logic hdr_done;
    logic hdr_ok;
    logic [15:0] ext_addr;
    logic [15:0] res_addr;
    logic [15:0] rd_word;
    logic crc_clr;
    logic [15:0] ctrl_r;
    logic [15:0] mmd_ctl_r;
    logic [15:0] mmd_adr_r;
    logic [15:0] int_a_r;
    logic [15:0] int_b_r;
    logic [15:0] selftest_r;
    logic [15:0] mac_cfg_r;
    logic [15:0] an_ctrl_r;
    logic [15:0] an_adv_r;
    logic [15:0] txl_r;
    logic link_r;
    logic [15:0] partner_r;
    logic [1:0] crc_flags_r;
    logic [2:0] ev;
    logic [15:0] evcnt_r [3];

    // ---------------------------------------------------------------
    // Pin synchronisers and strap capture
    // ---------------------------------------------------------------
    // The reference clock is resampled, so it carries 10 ns of jitter.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pin_q1_r <= 10'h000;
            pin_q2_r <= 10'h000;
            mdc_d_r <= 1'b0;
        end
        else
        begin
            pin_q1_r <= {mdc_in, mdio_in, crystal_input_in,
                tx_level_strap_in, xtal50_strap_in, phy_addr_strap_in};
            pin_q2_r <= pin_q1_r;
            mdc_d_r <= pin_q2_r[9];
        end
    end
    assign refclk_out_led_pin_out = pin_q2_r[7]; // RL2
    assign mdc_rise = pin_q2_r[9] & ~mdc_d_r;
    assign mdio_bit = pin_q2_r[8];

    // Straps are taken once the synchronisers hold real pin levels.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            start_cnt_r <= 2'd0;
            strap_done_r <= 1'b0;
            init_r <= 1'b0;
            phy_addr_r <= 5'h00;
            txl_strap_r <= 1'b0;
            x50_strap_r <= 1'b0;
        end
        else
        begin
            init_r <= 1'b0;
            if (!strap_done_r)
            begin
                start_cnt_r <= start_cnt_r + 2'd1;
                if (start_cnt_r == STARTUP_LAST)
                begin
                    strap_done_r <= 1'b1; // RL6
                    init_r <= 1'b1;
                    phy_addr_r <= pin_q2_r[4:0];
                    txl_strap_r <= pin_q2_r[6];
                    x50_strap_r <= pin_q2_r[5];
                end
            end
        end
    end
    assign defaults = init_r | ctrl_r[CTRL_RST_BIT]; // RL7

    // ---------------------------------------------------------------
    // Management frame engine
    // ---------------------------------------------------------------
    assign hdr_full = {hdr_r, mdio_bit};
    assign hdr_done = strap_done_r && mdc_rise && state_r == FR_HDR
        && cnt_r == HDR_LAST;
    assign hdr_ok = hdr_full[12] && hdr_full[9:5] == phy_addr_r
        && (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE);
    assign ext_addr = (mmd_ctl_r[4:0] == MMD_DEV_PMA)
        ? {MMD_PMA_PAGE, mmd_adr_r[11:0]} : mmd_adr_r;
    assign res_addr = (hdr_full[4:0] == A_MMD_DATA[4:0]
        && mmd_ctl_r[15:14] != 2'b00) ? ext_addr
        : {11'h000, hdr_full[4:0]}; // RL4
    assign crc_clr = hdr_done && hdr_ok && hdr_full[11:10] == OP_READ
        && res_addr == A_CRC_FLAGS;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r <= FR_IDLE; // RL1
            cnt_r <= 4'd0;
            ones_r <= 6'd0;
            hdr_r <= 12'h000;
            sh_r <= 16'h0000;
            is_rd_r <= 1'b0;
            hit_r <= 1'b0;
            mdio_out_r <= 1'b0;
            mdio_oe_r <= 1'b0;
            wr_pulse_r <= 1'b0;
            wr_addr_r <= 16'h0000;
            wr_data_r <= 16'h0000;
        end
        else
        begin
            wr_pulse_r <= 1'b0;
            if (strap_done_r && mdc_rise)
            begin
                unique case (state_r)
                    FR_IDLE:
                    begin
                        if (mdio_bit)
                        begin
                            if (ones_r != PREAMBLE_ONES)
                                ones_r <= ones_r + 6'd1;
                        end
                        else
                        begin
                            if (ones_r == PREAMBLE_ONES)
                            begin
                                state_r <= FR_HDR; // RL23
                                cnt_r <= 4'd0;
                            end
                            ones_r <= 6'd0;
                        end
                    end
                    FR_HDR:
                    begin
                        hdr_r <= hdr_full[11:0];
                        cnt_r <= cnt_r + 4'd1;
                        if (cnt_r == HDR_LAST)
                        begin
                            state_r <= FR_TA;
                            cnt_r <= 4'd0;
                            hit_r <= hdr_ok; // RL23
                            is_rd_r <= hdr_full[11:10] == OP_READ;
                            wr_addr_r <= res_addr;
                            sh_r <= rd_word;
                        end
                    end
                    FR_TA:
                    begin
                        cnt_r <= cnt_r + 4'd1;
                        if (cnt_r == 4'd0)
                        begin
                            if (hit_r && is_rd_r)
                            begin
                                mdio_oe_r <= 1'b1;
                                mdio_out_r <= 1'b0;
                            end
                        end
                        else
                        begin
                            state_r <= FR_DATA;
                            cnt_r <= 4'd0;
                            if (hit_r && is_rd_r)
                            begin
                                mdio_out_r <= sh_r[15];
                                sh_r <= {sh_r[14:0], 1'b0};
                            end
                        end
                    end
                    FR_DATA:
                    begin
                        cnt_r <= cnt_r + 4'd1;
                        sh_r <= {sh_r[14:0], is_rd_r ? 1'b0 : mdio_bit};
                        mdio_out_r <= is_rd_r & hit_r & sh_r[15];
                        if (cnt_r == DATA_LAST)
                        begin
                            state_r <= FR_IDLE;
                            mdio_oe_r <= 1'b0;
                            mdio_out_r <= 1'b0;
                            wr_pulse_r <= hit_r & ~is_rd_r;
                            wr_data_r <= {sh_r[14:0], mdio_bit};
                        end
                    end
                endcase
            end
        end
    end
    assign mdio_out = mdio_out_r;
    assign mdio_oe_out = mdio_oe_r;

    always_comb
    begin
        case (res_addr)
            A_BASIC_CONTROL: rd_word = ctrl_r;
            A_MODEL_REV: rd_word = MODEL_ID; // RL5
            A_MMD_CTRL: rd_word = mmd_ctl_r;
            A_MMD_DATA: rd_word = mmd_adr_r;
            A_LINK_STATUS: rd_word = {15'h0000, link_r}; // RL8
            A_INT_CTRL_A: rd_word = int_a_r;
            A_INT_CTRL_B: rd_word = int_b_r;
            A_RX_ERR_CNT: rd_word = evcnt_r[0]; // RL9
            A_SELFTEST: rd_word = selftest_r;
            A_MAC_CFG: rd_word = mac_cfg_r;
            A_CRC_FLAGS: rd_word = {14'h0000, crc_flags_r};
            A_TX_CRC_CNT: rd_word = evcnt_r[1];
            A_RX_CRC_CNT: rd_word = evcnt_r[2];
            A_AN_CTRL: rd_word = an_ctrl_r;
            A_AN_ADV: rd_word = an_adv_r;
            A_AN_PARTNER: rd_word = partner_r;
            A_TXL_EEE: rd_word = txl_r;
            default: rd_word = R_ZERO;
        endcase
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    // A digital reset restores every default, strap-derived ones included.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_r <= R_BASIC_CONTROL;
            mmd_ctl_r <= R_ZERO;
            mmd_adr_r <= R_ZERO;
            int_a_r <= R_ZERO;
            int_b_r <= R_ZERO;
            selftest_r <= R_SELFTEST;
            mac_cfg_r <= R_MAC_CFG;
            an_ctrl_r <= R_AN_CTRL;
            an_adv_r <= R_AN_ADV;
            txl_r <= R_ZERO;
        end
        else if (defaults)
        begin
            ctrl_r <= R_BASIC_CONTROL; // RL7
            mmd_ctl_r <= R_ZERO;
            mmd_adr_r <= R_ZERO;
            int_a_r <= R_ZERO;
            int_b_r <= R_ZERO;
            selftest_r <= R_SELFTEST; // RL10
            mac_cfg_r <= R_MAC_CFG | (16'(x50_strap_r) << MAC_XTAL_BIT); // RL12
            an_ctrl_r <= R_AN_CTRL; // RL16
            an_adv_r <= R_AN_ADV; // RL17
            txl_r <= R_ZERO | (16'(txl_strap_r) << TXL_LEVEL_BIT); // RL22
        end
        else
        begin
            an_ctrl_r[AN_RST_BIT] <= 1'b0;
            if (wr_pulse_r)
            begin
                case (wr_addr_r)
                    A_BASIC_CONTROL: ctrl_r <= wr_data_r; // RL21
                    A_MMD_CTRL: mmd_ctl_r <= wr_data_r; // RL4
                    A_MMD_DATA: mmd_adr_r <= wr_data_r;
                    A_INT_CTRL_A: int_a_r <= wr_data_r;
                    A_INT_CTRL_B: int_b_r <= wr_data_r;
                    A_SELFTEST: selftest_r <= wr_data_r; // RL21
                    A_MAC_CFG: mac_cfg_r <= wr_data_r; // RL11
                    A_AN_CTRL: an_ctrl_r <= wr_data_r; // RL16
                    A_AN_ADV: an_adv_r <= wr_data_r;
                    A_TXL_EEE: txl_r <= wr_data_r; // RL20
                    default: ;
                endcase
            end
        end
    end
    assign digital_reset_out = ctrl_r[CTRL_RST_BIT];
    assign mii_loopback_out = ctrl_r[CTRL_LOOP_BIT];
    assign loop_mode_out = selftest_r[6:0];
    assign sleep_out = selftest_r[SLEEP_BIT];
    assign mac_config_out = mac_cfg_r;
    assign autoneg_en_out = an_ctrl_r[AN_EN_BIT];
    assign autoneg_restart_out = an_ctrl_r[AN_RST_BIT];
    assign an_adv_out = an_adv_r;
    assign tx_level_2v4_out = txl_r[TXL_LEVEL_BIT]; // RL19
    assign eee_en_out = txl_r[TXL_EEE_BIT]; // RL18

    // ---------------------------------------------------------------
    // Status, flags and counters
    // ---------------------------------------------------------------
    // The flags clear as they are read; a new error in that cycle stays set.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            link_r <= 1'b0;
            partner_r <= R_ZERO;
            crc_flags_r <= 2'b00;
        end
        else
        begin
            link_r <= link_up_in; // RL8
            partner_r <= partner_adv_in;
            if (defaults)
                crc_flags_r <= 2'b00;
            else
                crc_flags_r <= (crc_flags_r & ~{2{crc_clr}})
                    | {rx_crc_err_in, tx_crc_err_in}; // RL13
        end
    end

    // Counters stick at full scale rather than wrap to a small value.
    assign ev = {rx_crc_err_in, tx_crc_err_in, rx_error_in};
    for (genvar g = 0; g < 3; g++)
    begin : g_cnt
        always_ff @(posedge clk_in or negedge rst_n_in)
        begin
            if (!rst_n_in)
                evcnt_r[g] <= R_ZERO;
            else if (defaults)
                evcnt_r[g] <= R_ZERO;
            else if (ev[g] && evcnt_r[g] != CNT_MAX)
                evcnt_r[g] <= evcnt_r[g] + 16'h0001; // RL9 RL14 RL15
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence read_hdr_s;
        hdr_done && hdr_ok && hdr_full[11:10] == OP_READ;
    endsequence
    sequence ta_wait_s;
        state_r == FR_TA && !mdio_oe_r;
    endsequence

    oe_in_frame_a: assert property (mdio_oe_r |-> hit_r && is_rd_r // RL23
        && (state_r == FR_TA || state_r == FR_DATA))
        else $error("data line driven outside a read");
    read_ta_a: assert property (read_hdr_s |=> ta_wait_s) // RL23
        else $error("turnaround not entered after read header");
    no_access_a: assert property (!strap_done_r |-> !mdio_oe_r // RL1
        && state_r == FR_IDLE)
        else $error("access before reset release");
    model_id_a: assert property (read_hdr_s and hdr_full[4:0] == 5'h03 // RL5
        |=> sh_r == MODEL_ID)
        else $error("model code read wrong");
    ext_only_a: assert property (hdr_done && mmd_ctl_r[15:14] == 2'b00 // RL4
        |-> res_addr <= 16'h001F)
        else $error("direct frame reached an extended address");
    ctrl_self_a: assert property (ctrl_r[CTRL_RST_BIT] |=> // RL7
        ctrl_r == R_BASIC_CONTROL && selftest_r == R_SELFTEST)
        else $error("digital reset did not restore defaults");
    link_read_a: assert property (read_hdr_s and hdr_full[4:0] == 5'h10 // RL8
        |=> sh_r[0] == $past(link_up_in, 2))
        else $error("link bit read wrong");
    rx_count_a: assert property (rx_error_in && !defaults // RL9
        && evcnt_r[0] != CNT_MAX |=> evcnt_r[0] == $past(evcnt_r[0]) + 16'h1)
        else $error("receive error not counted");
    strap_load_a: assert property ($rose(strap_done_r) |=> ##1 // RL22
        txl_r[TXL_LEVEL_BIT] == txl_strap_r
        && mac_cfg_r[MAC_XTAL_BIT] == x50_strap_r)
        else $error("strap defaults not applied");
    defaults_a: assert property (init_r |=> selftest_r == R_SELFTEST // RL10
        && mac_cfg_r[15:8] == R_MAC_CFG[15:8] && an_ctrl_r == R_AN_CTRL
        && an_adv_r == R_AN_ADV)
        else $error("reset values wrong");
    crc_set_a: assert property (tx_crc_err_in && !defaults // RL13
        |=> crc_flags_r[CRC_TX_BIT])
        else $error("transmit CRC flag lost");
    an_pulse_a: assert property (an_ctrl_r[AN_RST_BIT] |=> // RL16
        !an_ctrl_r[AN_RST_BIT])
        else $error("negotiation restart did not self-clear");
endmodule
`default_nettype wire

// *** pkg/t1l_mgmt_pkg.sv ***
`default_nettype none
package t1l_mgmt_pkg;
    // -----------------------------------------------------------------
    // Register addresses
    // -----------------------------------------------------------------
    localparam logic [15:0] A_BASIC_CONTROL = 16'h0000;
    localparam logic [15:0] A_MODEL_REV = 16'h0003;
    localparam logic [15:0] A_MMD_CTRL = 16'h000D;
    localparam logic [15:0] A_MMD_DATA = 16'h000E;
    localparam logic [15:0] A_LINK_STATUS = 16'h0010;
    localparam logic [15:0] A_INT_CTRL_A = 16'h0012;
    localparam logic [15:0] A_INT_CTRL_B = 16'h0013;
    localparam logic [15:0] A_RX_ERR_CNT = 16'h0015;
    localparam logic [15:0] A_SELFTEST = 16'h0016;
    localparam logic [15:0] A_MAC_CFG = 16'h0017;
    localparam logic [15:0] A_CRC_FLAGS = 16'h012A;
    localparam logic [15:0] A_TX_CRC_CNT = 16'h012D;
    localparam logic [15:0] A_RX_CRC_CNT = 16'h0130;
    localparam logic [15:0] A_AN_CTRL = 16'h0200;
    localparam logic [15:0] A_AN_ADV = 16'h020E;
    localparam logic [15:0] A_AN_PARTNER = 16'h020F;
    localparam logic [15:0] A_TXL_EEE = 16'h18F6;
    // -----------------------------------------------------------------
    // Reset values and fields
    // -----------------------------------------------------------------
    localparam logic [15:0] R_BASIC_CONTROL = 16'h0000;
    localparam logic [15:0] R_SELFTEST = 16'h0100;
    localparam logic [15:0] R_MAC_CFG = 16'h4001;
    localparam logic [15:0] R_AN_CTRL = 16'h1000;
    localparam logic [15:0] R_AN_ADV = 16'hA000;
    localparam logic [15:0] R_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam int CTRL_RST_BIT = 15;
    localparam int CTRL_LOOP_BIT = 14;
    localparam int SLEEP_BIT = 8;
    localparam int MAC_XTAL_BIT = 7;
    localparam int AN_RST_BIT = 15;
    localparam int AN_EN_BIT = 12;
    localparam int TXL_LEVEL_BIT = 12;
    localparam int TXL_EEE_BIT = 10;
    localparam int CRC_RX_BIT = 1;
    localparam int CRC_TX_BIT = 0;
    // -----------------------------------------------------------------
    // Management frame
    // -----------------------------------------------------------------
    localparam logic [4:0] MMD_DEV_PMA = 5'h01;
    localparam logic [3:0] MMD_PMA_PAGE = 4'h1;
    localparam logic [5:0] PREAMBLE_ONES = 6'd32;
    localparam logic [3:0] HDR_LAST = 4'd12;
    localparam logic [3:0] DATA_LAST = 4'd15;
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [1:0] STARTUP_LAST = 2'd3;
    localparam int CLK_KHZ = 100000;
    localparam int MDC_MAX_KHZ = 1750;
    localparam int MDC_MIN_CYC = (CLK_KHZ + MDC_MAX_KHZ - 1) / MDC_MAX_KHZ;
    typedef enum logic [1:0] {FR_IDLE, FR_HDR, FR_TA, FR_DATA} frame_state_t;
endpackage
`default_nettype wire

// *** bench/mgmt_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module mgmt_host
    import t1l_mgmt_pkg::*;
(
    output logic mdc_out,
    output logic mdio_out,
    output logic mdio_oe_out,
    input wire logic mdio_in
);
    // --------
    // Frame driver
    // --------
    // Bits change a quarter into the low phase, so they are settled at every rise.
    task automatic frame(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        logic rd_op;
        bits = {32'hFFFFFFFF, 2'b01, op, phy, ra, 2'b10, wd};
        rd_op = (op == OP_READ);
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--)
        begin
            mdc_out = 1'b0;
            #20;
            if (rd_op && i < 16)
                rd[i] = mdio_in;
            mdio_oe_out = !(rd_op && i < 18);
            mdio_out = bits[i];
            #60;
            mdc_out = 1'b1;
            // A real host stays at or below 1.75 MHz; this faster clock
            // only shortens the run, as the block samples far above it.
            #80;
        end
        // The clock stands low between frames; the pull-up holds the line.
        mdc_out = 1'b0;
        mdio_oe_out = 1'b0;
        #160;
    endtask
    initial
    begin
        mdc_out = 1'b0;
        mdio_out = 1'b0;
        mdio_oe_out = 1'b0;
    end
endmodule
`default_nettype wire

// *** bench/tb_t1l_phy_mgmt_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_t1l_phy_mgmt_regs
    import t1l_mgmt_pkg::*;
;
    localparam logic [15:0] ID = 16'h3C5A; // Arbitrary value.
    localparam logic [4:0] PHY = 5'h05;
    logic clk_in = 1'b0;
    logic rst_n = 1'b0;
    logic xtal = 1'b0;
    logic rx_err = 1'b0;
    logic tx_crc = 1'b0;
    logic rx_crc = 1'b0;
    logic link = 1'b0;
    logic mdc, h_out, h_oe, d_out, d_oe, mdio, refclk, dig_rst, mii_lb;
    logic sleep, an_en, an_rst, txl, eee;
    logic [6:0] lmode;
    logic [15:0] mcfg, adv, rv;
    int bad_count = 0;
    int tests_run = 0;
    int oe_n = 0;
    int dr_n = 0;
    int ar_n = 0;
    int ck_n = 0;
    int n;
    logic [36:0] tbl [16] = '{
        {5'h00, 16'h0000, 16'h0000}, {5'h00, 16'h0003, ID},
        {5'h00, 16'h0010, 16'h0000}, {5'h00, 16'h0012, 16'h0000},
        {5'h00, 16'h0013, 16'h0000}, {5'h00, 16'h0015, 16'h0000},
        {5'h00, 16'h0016, 16'h0100}, {5'h00, 16'h0017, 16'h4081},
        {5'h00, 16'h001F, 16'h0000}, {5'h1F, 16'h012A, 16'h0000},
        {5'h1F, 16'h012D, 16'h0000}, {5'h1F, 16'h0130, 16'h0000},
        {5'h1F, 16'h0200, 16'h1000}, {5'h1F, 16'h020E, 16'hA000},
        {5'h1F, 16'h020F, 16'h1234}, {5'h01, 16'h08F6, 16'h1000}};
    // The wire has a pull-up, so a released line reads high.
    assign mdio = d_oe ? d_out : (h_oe ? h_out : 1'b1);
    initial forever #5 clk_in = ~clk_in;
    initial forever #20 xtal = ~xtal;
    always @(posedge clk_in)
    begin
        oe_n <= oe_n + (d_oe === 1'b1);
        dr_n <= dr_n + (dig_rst === 1'b1);
        ar_n <= ar_n + (an_rst === 1'b1);
    end
    always @(posedge refclk) ck_n <= ck_n + 1;
    mgmt_host u_host (.mdc_out(mdc), .mdio_out(h_out), .mdio_oe_out(h_oe),
        .mdio_in(mdio));
    t1l_phy_mgmt_regs #(.MODEL_ID(ID)) u_dut (.clk_in(clk_in),
        .rst_n_in(rst_n), .crystal_input_in(xtal), .mdc_in(mdc),
        .mdio_in(mdio), .mdio_out(d_out), .mdio_oe_out(d_oe),
        .phy_addr_strap_in(PHY), .tx_level_strap_in(1'b1),
        .xtal50_strap_in(1'b1), .link_up_in(link), .rx_error_in(rx_err),
        .tx_crc_err_in(tx_crc), .rx_crc_err_in(rx_crc),
        .partner_adv_in(16'h1234), .refclk_out_led_pin_out(refclk),
        .digital_reset_out(dig_rst), .mii_loopback_out(mii_lb),
        .loop_mode_out(lmode), .sleep_out(sleep), .mac_config_out(mcfg),
        .autoneg_en_out(an_en), .autoneg_restart_out(an_rst),
        .an_adv_out(adv), .tx_level_2v4_out(txl), .eee_en_out(eee));
    // --------
    // Access tasks
    // --------
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        u_host.frame(OP_READ, PHY, a, 16'h0000, d);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] x;
        u_host.frame(OP_WRITE, PHY, a, d, x);
    endtask
    task automatic ext(input logic [4:0] dv, input logic [15:0] a);
        wr(5'h0D, {11'h000, dv});
        wr(5'h0E, a);
        wr(5'h0D, {11'h200, dv});
    endtask
    task automatic get(input logic [4:0] dv, input logic [15:0] a,
        output logic [15:0] d);
        if (dv != 5'h00)
            ext(dv, a);
        rd((dv != 5'h00) ? 5'h0E : a[4:0], d);
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #1000000;
        bad_count++;
        test_done();
    end
    initial
    begin
        repeat (3) @(negedge clk_in);
        rst_n = 1'b1;
        repeat (20) @(negedge clk_in);
        for (int i = 0; i < 16; i++)
        begin
            get(tbl[i][36:32], tbl[i][31:16], rv);
            check("reset", rv, tbl[i][15:0]);
        end
        n = ck_n;
        repeat (100) @(negedge clk_in);
        check("refclk", 16'((ck_n - n) inside {[24:26]}), 16'h0001);
        $display("test reset values done");
        link = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            @(negedge clk_in);
            rx_err = 1'b1;
            tx_crc = (i < 2);
            rx_crc = (i < 1);
            @(negedge clk_in);
            {rx_err, tx_crc, rx_crc} = 3'b000;
        end
        rd(5'h15, rv);
        check("rx errors", rv, 16'h0003);
        get(5'h1F, 16'h012D, rv);
        check("tx crc count", rv, 16'h0002);
        get(5'h1F, 16'h0130, rv);
        check("rx crc count", rv, 16'h0001);
        get(5'h1F, 16'h012A, rv);
        check("crc flags", rv, 16'h0003);
        rd(5'h0E, rv);
        check("crc flags cleared", rv, 16'h0000);
        rd(5'h10, rv);
        check("link", 16'(rv[0]), 16'h0001);
        $display("test counters done");
        wr(5'h00, 16'h4000);
        check("mii loopback", 16'(mii_lb), 16'h0001);
        wr(5'h16, 16'h0104);
        check("loop sleep", 16'({sleep, lmode}), 16'h0084);
        wr(5'h16, 16'h0000);
        check("sleep off", 16'(sleep), 16'h0000);
        wr(5'h17, 16'h1AA0);
        check("mac config", mcfg, 16'h1AA0);
        ext(5'h01, 16'h08F6);
        wr(5'h0E, 16'h0400);
        check("level eee", 16'({txl, eee}), 16'h0001);
        wr(5'h0E, 16'h1400);
        check("level eee", 16'({txl, eee}), 16'h0003);
        ext(5'h1F, 16'h020E);
        wr(5'h0E, 16'h8000);
        check("advert", adv, 16'h8000);
        ext(5'h1F, 16'h0200);
        wr(5'h0E, 16'h0000);
        check("an off", 16'(an_en), 16'h0000);
        n = ar_n;
        wr(5'h0E, 16'h9000);
        check("an restart", {15'(ar_n - n), an_en}, 16'h0003);
        $display("test writes done");
        n = dr_n;
        wr(5'h00, 16'h8000);
        check("digital reset", 16'(dr_n - n), 16'h0001);
        rd(5'h16, rv);
        check("selftest after reset", rv, 16'h0100);
        rd(5'h15, rv);
        check("rx errors after reset", rv, 16'h0000);
        $display("test digital reset done");
        n = oe_n;
        u_host.frame(OP_WRITE, 5'h06, 5'h16, 16'h0000, rv);
        u_host.frame(OP_READ, 5'h06, 5'h03, 16'h0000, rv);
        check("other phy", {15'(oe_n - n), sleep}, 16'h0001);
        @(negedge clk_in);
        rst_n = 1'b0;
        n = oe_n;
        rd(5'h03, rv);
        check("held reset", {15'(oe_n - n), mcfg[7]}, 16'h0000);
        $display("test refused done");
        test_done();
    end
endmodule
`default_nettype wire
